// [rtl/cfg_port_pkg.sv]
package cfg_port_pkg;

    // register map, byte addresses on the apb side
    localparam int PADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0c;
    localparam logic [7:0] OFF_BUS_RD = 8'h10;
    localparam logic [7:0] OFF_BUS_WR = 8'h14;

    // control register fields
    localparam int CTRL_W = 6;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 3;
    localparam int CTRL_DONE_BIT = 3;
    localparam int CTRL_BUS_EN_BIT = 4;
    localparam int CTRL_IRQ_BIT = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SEL_BIT = 1;
    localparam int ST_HOST_WR_BIT = 2;
    localparam int ST_ACK_BIT = 3;

    // pin widths and reset values
    localparam int DATA_PINS = 8;
    localparam int ADDR_PINS = 18;
    localparam logic [17:0] ADDR_RST = 18'h00000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] STATUS_OE = 8'h80;
    localparam logic [7:0] ALL_OE = 8'hff;

    typedef enum logic [2:0] {
        MODE_PERIPH,
        MODE_SLAVE_PAR,
        MODE_MASTER_PAR,
        MODE_SERIAL,
        MODE_BUS_A,
        MODE_BUS_B
    } cfg_mode_e;

    typedef enum logic {
        HS_IDLE,
        HS_ACK
    } host_state_e;

    // raw pin inputs, all asynchronous to ref_clk
    typedef struct packed {
        logic if_clock;
        logic sel_low_n;
        logic sel_high;
        logic strobe_n;
        logic write_n;
        logic rw_dir;
        logic [7:0] data;
    } pin_in_s;

    localparam int PIN_W = 14;
    // idle pin levels for the synchroniser reset: pulled-up pins high, host clock low,
    // so no false strobe edge or select is seen right after reset
    localparam logic [13:0] PIN_IDLE = 14'h1fff;

endpackage

// [rtl/config_and_host_bus_port.sv]
`timescale 1ns/1ps
// Overview of operation
// - selected only when low select low, high select high
// - read strobe low drives ready/busy on bit 7
// - selected write strobe low captures data byte
// - write strobe wins over simultaneous status read
// - master parallel mode drives 18-bit address
// - other configuration modes float address pins
// - interrupt request output is active low
// - first bus gets burst inhibit output
// - acknowledge high on first bus, low second
// - read/write polarity decoded per host bus
// - host pins become user I/O when unused
// - ready output mirrors status bit seven
// - host signals timed by host interface clock
// - data pins input except status bit 7 and host bus reads
module config_and_host_bus_port (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_sel_low_n,
    input wire logic chip_sel_high,
    input wire logic host_transfer_strobe_n,
    input wire logic write_strobe_n,
    input wire logic host_rw_dir,
    input wire logic host_if_clock,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe,
    output logic [17:0] addr_out,
    output logic addr_oe,
    output logic cfg_ready,
    output logic host_irq_n,
    output logic host_burst_inhibit,
    output logic host_xfer_ack,
    output logic host_if_oe,
    output logic user_io_mode
);

    logic [1:0] rst_pipe;
    logic rst_sync_n;
    logic [13:0] sync1;
    logic [13:0] sync2;
    cfg_port_pkg::pin_in_s pin_raw;
    cfg_port_pkg::pin_in_s pins;

    // reset enters asynchronously, leaves through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_sync_n = rst_pipe[1];

    assign pin_raw = '{if_clock: host_if_clock, sel_low_n: chip_sel_low_n,
                       sel_high: chip_sel_high, strobe_n: host_transfer_strobe_n,
                       write_n: write_strobe_n, rw_dir: host_rw_dir, data: data_in};

    // two-flop synchroniser per pin; only sync2 is read by logic
    generate
        for (genvar i = 0; i < cfg_port_pkg::PIN_W; i++)
        begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    sync1[i] <= cfg_port_pkg::PIN_IDLE[i];
                    sync2[i] <= cfg_port_pkg::PIN_IDLE[i];
                end
                else
                begin
                    sync1[i] <= pin_raw[i];
                    sync2[i] <= sync1[i];
                end
            end
        end
    endgenerate
    assign pins = cfg_port_pkg::pin_in_s'(sync2);

    // state
    logic [5:0] ctrl, next_ctrl;
    logic [17:0] addr_reg, next_addr_reg;
    logic [7:0] buf_byte, next_buf_byte;
    logic [7:0] bus_rdata, next_bus_rdata;
    logic [7:0] bus_wdata, next_bus_wdata;
    logic busy, next_busy;
    logic host_wr_flag, next_host_wr_flag;
    logic wr_seen, next_wr_seen;
    logic clk_seen, next_clk_seen;
    logic acc_write, next_acc_write;
    cfg_port_pkg::host_state_e state, next_state;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [7:0] next_data_out, next_data_oe;
    logic [17:0] next_addr_out;
    logic next_addr_oe, next_cfg_ready, next_host_irq_n, next_burst;
    logic next_ack, next_host_if_oe, next_user_io_mode;

    // decodes from synchronised pins and control
    cfg_port_pkg::cfg_mode_e mode;
    logic cfg_done, bus_en, in_cfg, selected, bus_mode, bus_active;
    logic capture, status_rd, hclk_rise, start, start_write;
    logic apb_access, apb_done, consume, host_wr_clear, mapped;

    assign mode = cfg_port_pkg::cfg_mode_e'(ctrl[cfg_port_pkg::CTRL_MODE_LSB +:
                                                 cfg_port_pkg::CTRL_MODE_W]);
    assign cfg_done = ctrl[cfg_port_pkg::CTRL_DONE_BIT];
    assign bus_en = ctrl[cfg_port_pkg::CTRL_BUS_EN_BIT];
    assign in_cfg = !cfg_done;
    assign selected = !pins.sel_low_n && pins.sel_high;
    assign bus_mode = (mode == cfg_port_pkg::MODE_BUS_A) || (mode == cfg_port_pkg::MODE_BUS_B);
    // after configuration the port only lives if enabled
    assign bus_active = bus_mode && (in_cfg || bus_en);

    // one capture per strobe pulse: edge on the synchronised low level
    assign capture = (mode == cfg_port_pkg::MODE_PERIPH) && in_cfg && selected
                     && !pins.write_n && !wr_seen;
    // status read only while write strobe is idle
    assign status_rd = (mode == cfg_port_pkg::MODE_PERIPH) && in_cfg && selected
                       && !pins.strobe_n && pins.write_n;

    // host side is stepped by rising edges of its own clock
    assign hclk_rise = pins.if_clock && !clk_seen;
    assign start = hclk_rise && (state == cfg_port_pkg::HS_IDLE) && bus_active
                   && selected && !pins.strobe_n;
    // first bus writes on low, second on high
    assign start_write = (mode == cfg_port_pkg::MODE_BUS_A) ? !pins.rw_dir
                                                             : pins.rw_dir;

    // apb: pready rises one cycle into the access phase
    assign apb_access = psel && penable && !pready;
    assign apb_done = psel && penable && pready;
    assign consume = apb_done && !pwrite && (paddr == cfg_port_pkg::OFF_DATA);
    assign host_wr_clear = apb_done && !pwrite && (paddr == cfg_port_pkg::OFF_BUS_WR);
    assign mapped = (paddr == cfg_port_pkg::OFF_CTRL) || (paddr == cfg_port_pkg::OFF_STATUS)
                    || (paddr == cfg_port_pkg::OFF_DATA) || (paddr == cfg_port_pkg::OFF_ADDR)
                    || (paddr == cfg_port_pkg::OFF_BUS_RD) || (paddr == cfg_port_pkg::OFF_BUS_WR);

    // register file and apb answer
    always_comb
    begin
        next_ctrl = ctrl;
        next_addr_reg = addr_reg;
        next_bus_rdata = bus_rdata;
        next_pready = apb_access;
        next_pslverr = apb_access && !mapped;
        next_prdata = 32'h0000_0000;
        if (apb_done && pwrite)
        begin
            case (paddr)
                cfg_port_pkg::OFF_CTRL: next_ctrl = pwdata[5:0];
                cfg_port_pkg::OFF_ADDR: next_addr_reg = pwdata[17:0];
                cfg_port_pkg::OFF_BUS_RD: next_bus_rdata = pwdata[7:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (apb_access && !pwrite)
        begin
            case (paddr)
                cfg_port_pkg::OFF_CTRL: next_prdata = {26'h0, ctrl};
                cfg_port_pkg::OFF_STATUS: next_prdata = {28'h0, state == cfg_port_pkg::HS_ACK,
                                                         host_wr_flag, selected, busy};
                cfg_port_pkg::OFF_DATA: next_prdata = {24'h0, buf_byte};
                cfg_port_pkg::OFF_ADDR: next_prdata = {14'h0, addr_reg};
                cfg_port_pkg::OFF_BUS_RD: next_prdata = {24'h0, bus_rdata};
                cfg_port_pkg::OFF_BUS_WR: next_prdata = {24'h0, bus_wdata};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // peripheral buffer and host access engine
    always_comb
    begin
        next_wr_seen = !pins.write_n;
        next_clk_seen = pins.if_clock;
        next_buf_byte = capture ? pins.data : buf_byte;
        // a new byte in the same cycle as a consume keeps busy set
        next_busy = capture || (busy && !consume);
        next_state = state;
        next_acc_write = acc_write;
        next_bus_wdata = bus_wdata;
        next_host_wr_flag = host_wr_flag && !host_wr_clear;
        case (state)
            cfg_port_pkg::HS_IDLE:
            begin
                if (start)
                begin
                    next_state = cfg_port_pkg::HS_ACK;
                    next_acc_write = start_write;
                    if (start_write)
                    begin
                        next_bus_wdata = pins.data;
                        next_host_wr_flag = 1'b1;
                    end
                end
            end
            cfg_port_pkg::HS_ACK:
            begin
                // acknowledge stands for one host clock period
                if (hclk_rise || !bus_active)
                    next_state = cfg_port_pkg::HS_IDLE;
            end
            default: next_state = cfg_port_pkg::HS_IDLE;
        endcase
    end

    // pin drivers, all registered
    always_comb
    begin
        next_data_out = cfg_port_pkg::BYTE_RST;
        next_data_oe = cfg_port_pkg::BYTE_RST;
        if (status_rd)
        begin
            next_data_out[7] = !busy;
            next_data_oe = cfg_port_pkg::STATUS_OE;
        end
        else if ((next_state == cfg_port_pkg::HS_ACK) && !next_acc_write)
        begin
            next_data_out = bus_rdata;
            next_data_oe = cfg_port_pkg::ALL_OE;
        end
        next_addr_oe = (mode == cfg_port_pkg::MODE_MASTER_PAR) && in_cfg;
        next_addr_out = next_addr_oe ? addr_reg : cfg_port_pkg::ADDR_RST;
        next_cfg_ready = !next_busy;
        next_host_irq_n = !(bus_active && ctrl[cfg_port_pkg::CTRL_IRQ_BIT]);
        next_burst = bus_active && (mode == cfg_port_pkg::MODE_BUS_A);
        // idle level of the acknowledge follows the bus polarity
        if (mode == cfg_port_pkg::MODE_BUS_B)
            next_ack = !(next_state == cfg_port_pkg::HS_ACK);
        else
            next_ack = (next_state == cfg_port_pkg::HS_ACK);
        next_host_if_oe = bus_active;
        next_user_io_mode = cfg_done && !bus_en;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl <= cfg_port_pkg::CTRL_RST;
            addr_reg <= cfg_port_pkg::ADDR_RST;
            bus_rdata <= cfg_port_pkg::BYTE_RST;
            bus_wdata <= cfg_port_pkg::BYTE_RST;
            buf_byte <= cfg_port_pkg::BYTE_RST;
            busy <= 1'b0;
            host_wr_flag <= 1'b0;
            wr_seen <= 1'b0;
            clk_seen <= 1'b0;
            acc_write <= 1'b0;
            state <= cfg_port_pkg::HS_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            data_out <= cfg_port_pkg::BYTE_RST;
            data_oe <= cfg_port_pkg::BYTE_RST;
            addr_out <= cfg_port_pkg::ADDR_RST;
            addr_oe <= 1'b0;
            cfg_ready <= 1'b1;
            host_irq_n <= 1'b1;
            host_burst_inhibit <= 1'b0;
            host_xfer_ack <= 1'b0;
            host_if_oe <= 1'b0;
            user_io_mode <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            addr_reg <= next_addr_reg;
            bus_rdata <= next_bus_rdata;
            bus_wdata <= next_bus_wdata;
            buf_byte <= next_buf_byte;
            busy <= next_busy;
            host_wr_flag <= next_host_wr_flag;
            wr_seen <= next_wr_seen;
            clk_seen <= next_clk_seen;
            acc_write <= next_acc_write;
            state <= next_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            addr_out <= next_addr_out;
            addr_oe <= next_addr_oe;
            cfg_ready <= next_cfg_ready;
            host_irq_n <= next_host_irq_n;
            host_burst_inhibit <= next_burst;
            host_xfer_ack <= next_ack;
            host_if_oe <= next_host_if_oe;
            user_io_mode <= next_user_io_mode;
        end
    end

    // checks on the pin behaviour
    chk_select_gate: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (!selected && (state == cfg_port_pkg::HS_IDLE)) |=> $stable(buf_byte)
        && (state == cfg_port_pkg::HS_IDLE))
        else $error("access taken while not selected");
    chk_status_drive: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        status_rd |=> (data_oe == 8'h80) && (data_out[7] == !$past(busy)))
        else $error("status bit not driven on read strobe");
    chk_byte_capture: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        capture |=> busy && (buf_byte == $past(pins.data)))
        else $error("written byte not captured");
    chk_write_wins: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (selected && !pins.write_n && !pins.strobe_n && !bus_active) |=> (data_oe == 8'h00))
        else $error("status driven during write");
    chk_addr_drive: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        ((mode == cfg_port_pkg::MODE_MASTER_PAR) && in_cfg) |=> addr_oe
        && (addr_out == $past(addr_reg)))
        else $error("address bus not driven");
    chk_addr_float: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (mode != cfg_port_pkg::MODE_MASTER_PAR) |=> !addr_oe)
        else $error("address pins driven outside master mode");
    chk_irq_idle: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        !bus_active |=> host_irq_n)
        else $error("interrupt asserted while port idle");
    chk_burst_inh: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (bus_active && (mode == cfg_port_pkg::MODE_BUS_A)) |=> host_burst_inhibit)
        else $error("burst inhibit missing");
    chk_ack_pulse: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (start && (mode == cfg_port_pkg::MODE_BUS_B)) |=> !host_xfer_ack)
        else $error("ready not driven low");
    chk_rw_decode: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (start && (mode == cfg_port_pkg::MODE_BUS_A) && !pins.rw_dir) |=> host_wr_flag)
        else $error("write polarity wrong");
    chk_user_io: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        user_io_mode |-> !host_if_oe)
        else $error("host pins driven in user mode");
    chk_ready_mirror: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        cfg_ready == !busy)
        else $error("ready output differs from status");
    chk_busy_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (busy && !consume) |=> busy)
        else $error("busy dropped before consume");

endmodule

// [testbench/cfg_host_model.sv]
`timescale 1ns/1ps
// host side of the port: select pins, strobes, host clock and the shared byte lane
module cfg_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic host_xfer_ack,
    output logic chip_sel_low_n,
    output logic chip_sel_high,
    output logic host_transfer_strobe_n,
    output logic write_strobe_n,
    output logic host_rw_dir,
    output logic host_if_clock,
    output logic [7:0] data_in
);
    logic host_oe;
    logic [7:0] host_d;

    // lane level: device drive per bit, else host, else the pull-ups
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            data_in[i] = data_oe[i] ? data_out[i] : (host_oe ? host_d[i] : 1'b1);
        end
    end

    // idle pins; host clock stands still outside accesses
    initial
    begin
        chip_sel_low_n = 1'b0;
        chip_sel_high = 1'b1;
        host_transfer_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        host_rw_dir = 1'b0;
        host_if_clock = 1'b0;
        host_oe = 1'b0;
        host_d = 8'h00;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic select(input logic lo_n, input logic hi);
        @(posedge ref_clk);
        chip_sel_low_n <= lo_n;
        chip_sel_high <= hi;
    endtask

    // strobes held four cycles so the two-flop sync surely sees each edge
    task automatic periph_write(input logic [7:0] b, input logic with_read);
        @(posedge ref_clk);
        host_d <= b;
        host_oe <= 1'b1;
        write_strobe_n <= 1'b0;
        host_transfer_strobe_n <= !with_read;
        wait_clk(4);
        write_strobe_n <= 1'b1;
        host_transfer_strobe_n <= 1'b1;
        wait_clk(4);
        host_oe <= 1'b0;
    endtask

    // status poll: host leaves the lane to the device and samples bit seven
    task automatic status_read(output logic st, output logic [7:0] oe);
        @(posedge ref_clk);
        host_transfer_strobe_n <= 1'b0;
        wait_clk(4);
        st = data_in[7];
        oe = data_oe;
        host_transfer_strobe_n <= 1'b1;
        wait_clk(4);
    endtask

    // one access: strobe across a host clock rise, ack held to the next rise
    task automatic bus_xfer(input logic rw, input logic [7:0] wd, input logic drive,
        output logic ack, output logic [7:0] rd);
        @(posedge ref_clk);
        host_transfer_strobe_n <= 1'b0;
        host_rw_dir <= rw;
        host_d <= wd;
        host_oe <= drive;
        wait_clk(4);
        host_if_clock <= 1'b1;
        wait_clk(5);
        ack = host_xfer_ack;
        rd = data_in;
        host_transfer_strobe_n <= 1'b1;
        host_if_clock <= 1'b0;
        host_oe <= 1'b0;
        wait_clk(4);
        host_if_clock <= 1'b1;
        wait_clk(4);
        host_if_clock <= 1'b0;
        wait_clk(4);
    endtask
endmodule

// [testbench/config_and_host_bus_port_tb.sv]
`timescale 1ns/1ps
module config_and_host_bus_port_tb;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cs_lo_n, cs_hi, strb_n, wr_n, rw, hclk, err, st, ack;
    logic [7:0] din, dout, doe, oe, bd;
    logic [17:0] addr_out;
    logic addr_oe, cfg_ready, host_irq_n, host_burst_inhibit, host_xfer_ack;
    logic host_if_oe, user_io_mode;
    int n_mismatch = 0;
    int compares = 0;

    config_and_host_bus_port i_config_and_host_bus_port (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_sel_low_n(cs_lo_n),
        .chip_sel_high(cs_hi), .host_transfer_strobe_n(strb_n), .write_strobe_n(wr_n),
        .host_rw_dir(rw), .host_if_clock(hclk), .data_in(din), .data_out(dout),
        .data_oe(doe), .addr_out(addr_out), .addr_oe(addr_oe), .cfg_ready(cfg_ready),
        .host_irq_n(host_irq_n), .host_burst_inhibit(host_burst_inhibit),
        .host_xfer_ack(host_xfer_ack), .host_if_oe(host_if_oe), .user_io_mode(user_io_mode));

    cfg_host_model i_cfg_host_model (.ref_clk(ref_clk), .data_out(dout), .data_oe(doe),
        .host_xfer_ack(host_xfer_ack), .chip_sel_low_n(cs_lo_n), .chip_sel_high(cs_hi),
        .host_transfer_strobe_n(strb_n), .write_strobe_n(wr_n), .host_rw_dir(rw),
        .host_if_clock(hclk), .data_in(din));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // apb transfer: request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        chk("cfg_ready", 32'h1, cfg_ready);
        chk("irq_n", 32'h1, host_irq_n);
        apb(1'b0, cfg_port_pkg::OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        // peripheral byte, busy until software consumes it
        i_cfg_host_model.periph_write(8'ha5, 1'b0);
        chk("cfg_ready busy", 32'h0, cfg_ready);
        i_cfg_host_model.status_read(st, oe);
        chk("status oe", 32'h80, oe);
        chk("status busy", 32'h0, st);
        apb(1'b0, cfg_port_pkg::OFF_STATUS, 32'h0);
        chk("status reg", 32'h3, rd);
        apb(1'b0, cfg_port_pkg::OFF_DATA, 32'h0);
        chk("data byte", 32'ha5, rd);
        settle();
        chk("cfg_ready free", 32'h1, cfg_ready);
        i_cfg_host_model.status_read(st, oe);
        chk("status ready", 32'h1, st);
        // both strobes low: the write wins
        i_cfg_host_model.periph_write(8'h3c, 1'b1);
        apb(1'b0, cfg_port_pkg::OFF_DATA, 32'h0);
        chk("write wins", 32'h3c, rd);
        // each wrong select pairing must ignore the strobe
        for (int k = 0; k < 3; k++)
        begin
            settle();
            i_cfg_host_model.select(k < 2, k == 1);
            i_cfg_host_model.periph_write(8'h77, 1'b0);
            chk("deselected", 32'h1, cfg_ready);
        end
        i_cfg_host_model.select(1'b0, 1'b1);
        apb(1'b0, cfg_port_pkg::OFF_DATA, 32'h0);
        chk("kept byte", 32'h3c, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        // address pins: driven only in master parallel mode
        apb(1'b1, cfg_port_pkg::OFF_ADDR, 32'h0003ffff);
        apb(1'b1, cfg_port_pkg::OFF_CTRL, 32'h2);
        settle();
        chk("addr_oe", 32'h1, addr_oe);
        chk("addr_out", 32'h3ffff, addr_out);
        for (int m = 0; m < 4; m++)
        begin
            if (m != 2)
            begin
                apb(1'b1, cfg_port_pkg::OFF_CTRL, m);
                settle();
                chk("addr float", 32'h0, addr_oe);
            end
        end
        // first host bus, interrupt requested
        apb(1'b1, cfg_port_pkg::OFF_BUS_RD, 32'hc3);
        apb(1'b1, cfg_port_pkg::OFF_CTRL, 32'h24);
        settle();
        chk("burst inhibit", 32'h1, host_burst_inhibit);
        chk("irq_n on", 32'h0, host_irq_n);
        chk("ack idle a", 32'h0, host_xfer_ack);
        chk("if_oe a", 32'h1, host_if_oe);
        i_cfg_host_model.bus_xfer(1'b1, 8'h00, 1'b0, ack, bd);
        chk("ack a rd", 32'h1, ack);
        chk("bus rd a", 32'hc3, bd);
        i_cfg_host_model.bus_xfer(1'b0, 8'h5a, 1'b1, ack, bd);
        chk("ack a wr", 32'h1, ack);
        apb(1'b0, cfg_port_pkg::OFF_BUS_WR, 32'h0);
        chk("bus wr a", 32'h5a, rd);
        // second host bus: inverted direction and acknowledge
        apb(1'b1, cfg_port_pkg::OFF_CTRL, 32'h5);
        settle();
        chk("ack idle b", 32'h1, host_xfer_ack);
        chk("no inhibit b", 32'h0, host_burst_inhibit);
        chk("irq_n off", 32'h1, host_irq_n);
        i_cfg_host_model.bus_xfer(1'b1, 8'h96, 1'b1, ack, bd);
        chk("ack b wr", 32'h0, ack);
        apb(1'b0, cfg_port_pkg::OFF_BUS_WR, 32'h0);
        chk("bus wr b", 32'h96, rd);
        i_cfg_host_model.bus_xfer(1'b0, 8'h00, 1'b0, ack, bd);
        chk("bus rd b", 32'hc3, bd);
        chk("ack b rd", 32'h0, ack);
        // after configuration the pins fall back to user io unless the port is kept
        apb(1'b1, cfg_port_pkg::OFF_CTRL, 32'h0c);
        settle();
        chk("user io", 32'h1, user_io_mode);
        chk("if_oe user", 32'h0, host_if_oe);
        apb(1'b1, cfg_port_pkg::OFF_CTRL, 32'h1c);
        settle();
        chk("port kept", 32'h0, user_io_mode);
        chk("if_oe kept", 32'h1, host_if_oe);
        conclude();
    end
endmodule
